// ===== hw/lbc_defines.svh
/*
 Constants of the LED brightness and ambient light control block:
 register offset, field positions, reset values and timing counts.
 Assumes a 100 MHz system clock; included by its bare name.
*/
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

// clock and timing
`define LBC_CLK_PERIOD_NS 10
`define LBC_SAMPLE_PERIOD_NS 140000
`define LBC_SAMPLE_CYC (`LBC_SAMPLE_PERIOD_NS / `LBC_CLK_PERIOD_NS)
`define LBC_RAMP_BASE_CYC 100
`define LBC_DUTY_DIV_CYC 40

// readable sample register
`define LBC_REG_LIGHT_SAMPLE 8'h37
`define LBC_LIGHT_SAMPLE_RST 8'h00

// sensor configuration fields
`define LBC_SENSOR_EN_BIT 0
`define LBC_SENSOR_TYPE_BIT 1

// codes
`define LBC_RES_HIZ 7'h00
`define LBC_CODE_FULL 8'hFF
`define LBC_ZONE_TOP 3'h4
`define LBC_ZONE_RST 3'h0
`define LBC_CODE_DIV 255

`endif

// ===== hw/lbc_pkg.sv
/*
 Types of the LED brightness and ambient light control block.
 Assumes nothing of its surroundings.
*/
package lbc_pkg;

   // per-bank ramp sequencing
   typedef enum logic [1:0]
   {
      RAMP_OFF = 2'b00,
      RAMP_START = 2'b01,
      RAMP_RUN = 2'b10,
      RAMP_STOP = 2'b11
   } lbc_ramp_state_t;

   typedef logic [2:0] lbc_zone_t;

endpackage

// ===== hw/lbc_ramp.sv
/*
 Per-bank code ramp: walks the effective brightness code toward the target
 with start-up, shutdown and run-time step intervals.
 Assumes time selections are stable levels on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lbc_defines.svh"

module lbc_ramp
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // control
   input wire logic bankEnable,
   input wire logic [7:0] targetCode,
   input wire logic [2:0] startupTime,
   input wire logic [2:0] shutdownTime,
   input wire logic [2:0] rampUpTime,
   input wire logic [2:0] rampDownTime,
   // result
   output logic [7:0] rampCode,
   output logic rampActive
);

   localparam logic [15:0] BASE = 16'(`LBC_RAMP_BASE_CYC);

   lbc_pkg::lbc_ramp_state_t state;
   lbc_pkg::lbc_ramp_state_t next_state;
   logic [15:0] stepCnt;

   // step interval doubles per selection index
   function automatic logic [15:0] stepCycles(input logic [2:0] sel);
      stepCycles = BASE << sel;
   endfunction

   wire logic [7:0] goal = (state == lbc_pkg::RAMP_STOP ||
                            state == lbc_pkg::RAMP_OFF) ? 8'h00 : targetCode;
   wire logic goUp = rampCode < goal;
   wire logic goDown = rampCode > goal;
   wire logic [2:0] timeSel =
      (state == lbc_pkg::RAMP_START) ? startupTime :
      (state == lbc_pkg::RAMP_STOP) ? shutdownTime :
      goUp ? rampUpTime : rampDownTime;
   wire logic stepNow = (goUp | goDown) &&
                        (stepCnt >= stepCycles(timeSel) - 16'h0001);

   // sequencing: enable starts, disable shuts down to zero
   always_comb
   begin
      next_state = state;
      case (state)
         lbc_pkg::RAMP_OFF:
            if (bankEnable)
               next_state = lbc_pkg::RAMP_START;
         lbc_pkg::RAMP_START:
            if (!bankEnable)
               next_state = lbc_pkg::RAMP_STOP;
            else if (rampCode == targetCode)
               next_state = lbc_pkg::RAMP_RUN;
         lbc_pkg::RAMP_RUN:
            if (!bankEnable)
               next_state = lbc_pkg::RAMP_STOP;
         lbc_pkg::RAMP_STOP:
            if (bankEnable)
               next_state = lbc_pkg::RAMP_START;
            else if (rampCode == 8'h00)
               next_state = lbc_pkg::RAMP_OFF;
         default:
            next_state = lbc_pkg::RAMP_OFF;
      endcase
   end

   // one code step per interval, never past the goal
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= lbc_pkg::RAMP_OFF;
         stepCnt <= 16'h0000;
         rampCode <= 8'h00;
      end
      else
      begin
         state <= next_state;
         stepCnt <= (stepNow || !(goUp | goDown)) ? 16'h0000
                    : stepCnt + 16'h0001;
         if (stepNow)
            rampCode <= goUp ? rampCode + 8'h01 : rampCode - 8'h01;
      end
   end

   assign rampActive = (state != lbc_pkg::RAMP_OFF);

endmodule
`default_nettype wire

// ===== hw/lbc_top.sv
/*
 LED brightness control with pulse-input scaling and ambient light zoning.
 Computes per-bank sink current levels from brightness codes or zone
 targets, measures the pulse input duty, samples the light converter and
 tracks the light zone. Assumes configuration inputs are static levels from
 the host register file on clk_sys; pulseIn and converterCode come from pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lbc_defines.svh"

module lbc_top
#(
   parameter int NB = 6,
   parameter int SAMPLE_CYCLES = `LBC_SAMPLE_CYC,
   parameter int DUTY_DIV = `LBC_DUTY_DIV_CYC
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // bank configuration, index 0 is control bank 1
   input wire logic [NB-1:0] bankEnable,
   input wire logic [NB-1:0] bankLinear,
   input wire logic [NB-1:0] bankPulseEn,
   input wire logic [NB-1:0] bankZoneEn,
   input wire logic [NB-1:0] bankSetThree,
   input wire logic [NB*8-1:0] bankCode,
   input wire logic [NB*5-1:0] fullScaleCurrent,
   // global ramp times
   input wire logic [2:0] startupTime,
   input wire logic [2:0] shutdownTime,
   input wire logic [2:0] rampUpTime,
   input wire logic [2:0] rampDownTime,
   // pulse input pin
   input wire logic pulseIn,
   input wire logic pulseActiveLow,
   // ambient light sensing
   input wire logic [7:0] sensorCfg,
   input wire logic [6:0] resistorSelect,
   input wire logic [31:0] zoneBoundHigh,
   input wire logic [31:0] zoneBoundLow,
   input wire logic [39:0] zoneTargetSetOne,
   input wire logic [39:0] zoneTargetSetTwo,
   input wire logic [39:0] zoneTargetSetThree,
   input wire logic [4:0] zonePulseEn,
   input wire logic [7:0] converterCode,
   // sensor front end controls
   output logic converterStart,
   output logic sensorPulseMode,
   output logic [6:0] resistorEffective,
   // status
   output logic [7:0] lightSampleResult,
   output logic [2:0] lightZone,
   output logic [7:0] pulseDuty,
   // sink currents, 21 bits per bank, full scale code times 16-bit fraction
   output logic [NB*21-1:0] sinkCurrent
);

   // elaboration checks
   // counts beyond the counter widths would be truncated and end each period early
   if (NB < 3 || NB > 8)
      $error("lbc_top: NB must be 3..8");
   if (SAMPLE_CYCLES < 2 || DUTY_DIV < 1)
      $error("lbc_top: timing counts too small");
   if (SAMPLE_CYCLES > 1048576)
      $error("lbc_top: sample period exceeds its 20-bit counter");
   if (DUTY_DIV > 65536)
      $error("lbc_top: duty divider exceeds its 16-bit counter");

   // last counts of the sample timer and the duty divider
   localparam logic [19:0] SAMPLE_LAST = 20'(SAMPLE_CYCLES - 1);
   localparam logic [15:0] DUTY_LAST = 16'(DUTY_DIV - 1);

   // linear fraction: code/255 scaled to 16 bits, exact
   // code times 257 puts code 255 exactly on FFFF
   function automatic logic [15:0] linFrac(input logic [7:0] code);
      linFrac = {code, code};
   endfunction

   // exponential fraction: 0.862 per 5.5 codes, about 25.6 codes per
   // octave; octave from (255-code)*5/128, mantissa linear in octave
   function automatic logic [15:0] expFrac(input logic [7:0] code);
      logic [10:0] t;
      logic [8:0] m;
      logic [16:0] v;
      // t counts 128ths of an octave below full scale
      t = 11'(`LBC_CODE_FULL - code) * 11'd5;
      // mantissa falls linearly inside one octave, shift gives the octave
      m = 9'h100 - {2'b00, t[6:0]};
      v = {m, 8'h00} >> t[10:7];
      expFrac = (v > 17'h0FFFF) ? 16'hFFFF : v[15:0];
   endfunction

   // duty scaling of a fraction, 255 duty counts equal full
   function automatic logic [15:0] dutyScale(input logic [15:0] frac,
                                             input logic [7:0] duty);
      logic [31:0] p;
      p = frac * {duty, duty};
      dutyScale = p[31:16];
   endfunction

   // byte k of a packed table, shared by boundary and target lookups
   function automatic logic [7:0] pickByte(input logic [39:0] tbl,
                                           input logic [2:0] k);
      pickByte = tbl[8*k +: 8];
   endfunction

   // pin synchronisers, two flops before any logic reads a pin
   // the converter word is not gray coded: it is only taken at a start,
   // long after the converter last moved it, so no bit can be torn
   logic pulseMeta;
   logic pulseSync;
   logic [7:0] codeMeta;
   logic [7:0] codeSync;

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pulseMeta <= 1'b0;
         pulseSync <= 1'b0;
         codeMeta <= 8'h00;
         codeSync <= 8'h00;
      end
      else
      begin
         pulseMeta <= pulseIn;
         pulseSync <= pulseMeta;
         codeMeta <= converterCode;
         codeSync <= codeMeta;
      end
   end

   // duty measurement over 255 divided ticks
   // the last tick is folded into the result so a steady active level
   // reads back as 255, which dutyScale treats as full scale
   logic [15:0] dutyDiv;
   logic [7:0] dutyWin;
   logic [7:0] dutyAcc;
   wire logic dutyTick = (dutyDiv == DUTY_LAST);
   wire logic activeLevel = pulseActiveLow ? ~pulseSync : pulseSync;
   wire logic winEnd = dutyTick && (dutyWin == `LBC_CODE_FULL - 8'h01);

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dutyDiv <= 16'h0000;
         dutyWin <= 8'h00;
         dutyAcc <= 8'h00;
         pulseDuty <= 8'h00;
      end
      else
      begin
         dutyDiv <= dutyTick ? 16'h0000 : dutyDiv + 16'h0001;
         // window end: publish the count and start again
         if (winEnd)
         begin
            dutyWin <= 8'h00;
            dutyAcc <= 8'h00;
            pulseDuty <= dutyAcc + {7'h00, activeLevel};
         end
         else if (dutyTick)
         begin
            dutyWin <= dutyWin + 8'h01;
            dutyAcc <= dutyAcc + {7'h00, activeLevel};
         end
      end
   end

   // sensor front end selection
   // a pulse sensor needs the load open, so its mode overrides the select
   wire logic sensorEnable = sensorCfg[`LBC_SENSOR_EN_BIT];
   assign sensorPulseMode = sensorCfg[`LBC_SENSOR_TYPE_BIT];
   assign resistorEffective = sensorPulseMode ? `LBC_RES_HIZ
                              : resistorSelect;

   // sample timer, runs only while sensing is enabled
   // first start after enabling comes one full period later
   logic [19:0] sampleCnt;
   logic sampleTick;
   wire logic sampleDue = sensorEnable && (sampleCnt == SAMPLE_LAST);

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sampleCnt <= 20'h00000;
         sampleTick <= 1'b0;
         converterStart <= 1'b0;
         lightSampleResult <= `LBC_LIGHT_SAMPLE_RST;
      end
      else
      begin
         sampleCnt <= (!sensorEnable || sampleDue) ? 20'h00000
                      : sampleCnt + 20'h00001;
         converterStart <= sampleDue;
         sampleTick <= sampleDue;
         // take the code that was settled before this start
         if (sampleDue)
            lightSampleResult <= codeSync;
      end
   end

   // zone boundaries around the current zone
   wire logic [1:0] upIdx = lightZone[1:0];
   wire logic [1:0] downIdx = 2'(lightZone - 3'h1);
   // low boundary of the zone below guards the way down; unused in zone 0
   wire logic [7:0] boundHigh = pickByte({8'h00, zoneBoundHigh},
                                         {1'b0, upIdx});
   wire logic [7:0] boundLow = pickByte({8'h00, zoneBoundLow},
                                        {1'b0, downIdx});
   wire logic zoneUp = (lightZone < `LBC_ZONE_TOP) &&
                       (lightSampleResult > boundHigh);
   wire logic zoneDown = (lightZone != 3'h0) &&
                         (lightSampleResult < boundLow);

   // hysteretic zone tracking, one step per sample
   // a jump across several zones is walked one zone per sample
   wire logic stepUp = sampleTick && zoneUp;
   wire logic stepDown = sampleTick && zoneDown;

   // disabling wins so sensing always restarts from zone 0
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         lightZone <= `LBC_ZONE_RST;
      else if (!sensorEnable)
         lightZone <= `LBC_ZONE_RST;
      else if (stepUp)
         lightZone <= lightZone + 3'h1;
      else if (stepDown)
         lightZone <= lightZone - 3'h1;
   end

   // per-bank target selection, ramp and current mapping
   // each bank: choose target, ramp the code, map it, scale by duty,
   // multiply by its full scale setting, register the result
   genvar b;
   generate
      for (b = 0; b < NB; b++)
      begin : g_bank
         wire logic [39:0] setSel;
         wire logic [7:0] zoneCode;
         wire logic [7:0] targetCode;
         wire logic usePulse;
         wire logic [7:0] rampCode;
         wire logic rampActive;
         wire logic [15:0] frac;
         wire logic [15:0] scaled;
         wire logic [20:0] product;
         wire logic [7:0] ownCode;
         wire logic [4:0] fsCode;

         // bank one owns set one, others choose set two or three
         if (b == 0)
         begin : g_first
            assign setSel = zoneTargetSetOne;
         end
         else
         begin : g_other
            assign setSel = bankSetThree[b] ? zoneTargetSetThree
                            : zoneTargetSetTwo;
         end

         // zone mode follows the tracked zone, else the bank's own code
         assign zoneCode = pickByte(setSel, lightZone);
         assign ownCode = bankCode[8*b +: 8];
         assign fsCode = fullScaleCurrent[5*b +: 5];
         assign targetCode = bankZoneEn[b] ? zoneCode : ownCode;
         assign usePulse = bankZoneEn[b] ? zonePulseEn[lightZone]
                           : bankPulseEn[b];

         // timing selections are global, one sequencer per bank
         lbc_ramp u_ramp
         (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .bankEnable(bankEnable[b]),
            .targetCode(targetCode),
            .startupTime(startupTime),
            .shutdownTime(shutdownTime),
            .rampUpTime(rampUpTime),
            .rampDownTime(rampDownTime),
            .rampCode(rampCode),
            .rampActive(rampActive)
         );

         // mapping per bank, then duty, then full scale
         assign frac = !rampActive ? 16'h0000
                       : bankLinear[b] ? linFrac(rampCode)
                       : expFrac(rampCode);
         assign scaled = usePulse ? dutyScale(frac, pulseDuty) : frac;
         // a zero fraction gives exactly zero current
         assign product = frac == 16'h0000 ? 21'h000000
                          : scaled * fsCode;

         // registered so the current word never shows decode glitches
         always_ff @(posedge clk_sys or negedge rst_b)
         begin
            if (!rst_b)
               sinkCurrent[21*b +: 21] <= 21'h000000;
            else
               sinkCurrent[21*b +: 21] <= product;
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ===== sim/lbc_top_sva.sv
/*
 Checker on the ports of the brightness and light control top.
 Assumes one clock domain; bound from the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none

module lbc_top_sva
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // inputs
   input wire logic [7:0] sensorCfg,
   input wire logic [6:0] resistorSelect,
   input wire logic [31:0] zoneBoundHigh,
   input wire logic [31:0] zoneBoundLow,
   input wire logic [7:0] converterCode,
   // outputs
   input wire logic converterStart,
   input wire logic sensorPulseMode,
   input wire logic [6:0] resistorEffective,
   input wire logic [7:0] lightSampleResult,
   input wire logic [2:0] lightZone
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // boundaries around the present zone
   wire [7:0] hiNow = zoneBoundHigh[8*lightZone[1:0] +: 8];
   wire [7:0] loNow = zoneBoundLow[8*2'(lightZone[1:0] - 2'h1) +: 8];

   chk_start_gap: assert property (converterStart |=> !converterStart [*8])
      else $error("conversion starts too close");
   chk_start_enabled: assert property (converterStart |-> $past(sensorCfg[0]))
      else $error("conversion while sensing off");
   chk_sample_capture: assert property (converterStart |->
      lightSampleResult == $past(converterCode, 3))
      else $error("sample result not the converter code");
   chk_sample_hold: assert property (!converterStart |-> $stable(lightSampleResult))
      else $error("sample result moved between samples");
   chk_mode_copy: assert property (sensorPulseMode == sensorCfg[1])
      else $error("sensor mode not from type bit");
   chk_resistor_hiz: assert property (sensorPulseMode |-> resistorEffective == 7'h00)
      else $error("resistor not high impedance in pulse mode");
   chk_resistor_pass: assert property (!sensorCfg[1] |->
      resistorEffective == resistorSelect)
      else $error("resistor select not applied");
   chk_zone_range: assert property (lightZone <= 3'h4)
      else $error("zone out of range");
   chk_zone_rise: assert property ($past(converterStart) && $past(sensorCfg[0])
      && $past(lightZone) < 3'h4 && $past(lightSampleResult > hiNow)
      |-> lightZone == $past(lightZone) + 3'h1)
      else $error("zone did not rise one step");
   chk_zone_fall: assert property ($past(converterStart) && $past(sensorCfg[0])
      && $past(lightZone) != 3'h0 && $past(lightSampleResult < loNow)
      |-> lightZone == $past(lightZone) - 3'h1)
      else $error("zone did not fall one step");
   chk_zone_hold: assert property (!$past(converterStart) && $past(sensorCfg[0])
      |-> $stable(lightZone))
      else $error("zone moved without a sample");
   chk_zone_idle: assert property (!$past(sensorCfg[0]) |-> lightZone == 3'h0)
      else $error("zone not zero while sensing off");
   // main scenarios
   cov_sample: cover property (converterStart);
   cov_rise: cover property (lightZone > $past(lightZone));
   cov_fall: cover property (lightZone < $past(lightZone));
endmodule

bind lbc_top lbc_top_sva u_lbc_top_sva (.clk_sys(clk_sys), .rst_b(rst_b),
   .sensorCfg(sensorCfg), .resistorSelect(resistorSelect),
   .zoneBoundHigh(zoneBoundHigh), .zoneBoundLow(zoneBoundLow),
   .converterCode(converterCode), .converterStart(converterStart),
   .sensorPulseMode(sensorPulseMode), .resistorEffective(resistorEffective),
   .lightSampleResult(lightSampleResult), .lightZone(lightZone));
`default_nettype wire

// ===== sim/lbc_sensor_model.sv
/*
 Light converter stand-in: presents a new code after each conversion.
 Assumes converterStart is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none

module lbc_sensor_model
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // request and level to convert
   input wire logic converterStart,
   input wire logic [7:0] lightLevel,
   // converter pins
   output logic [7:0] converterCode
);
   // code changes only just after a start, so it is long settled
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         converterCode <= 8'h5A;
      else if (converterStart)
         converterCode <= lightLevel;
   end
endmodule
`default_nettype wire

// ===== sim/led_brightness_als_control_test.sv
/*
 Self-checking bench for the brightness and light control top.
 Assumes a short sample period and a one-cycle duty tick.
*/
`timescale 1ns/10ps
`default_nettype none

module led_brightness_als_control_test;
   logic clk_sys, rst_b, pulseIn, pulseActiveLow, converterStart;
   logic sensorPulseMode;
   logic [5:0] bankEnable, bankLinear, bankPulseEn, bankZoneEn, bankSetThree;
   logic [47:0] bankCode;
   logic [29:0] fullScaleCurrent;
   logic [2:0] startupTime, shutdownTime, rampUpTime, rampDownTime, lightZone;
   logic [7:0] sensorCfg, converterCode, lightLevel, lightSampleResult;
   logic [7:0] pulseDuty, code;
   logic [6:0] resistorSelect, resistorEffective;
   logic [31:0] zoneBoundHigh, zoneBoundLow, seed;
   logic [39:0] zoneTargetSetOne, zoneTargetSetTwo, zoneTargetSetThree;
   logic [4:0] zonePulseEn, fs;
   logic [125:0] sinkCurrent;
   logic [2:0] zone;
   int num_errors, n_checks, gap;

   lbc_top #(.NB(6), .SAMPLE_CYCLES(20), .DUTY_DIV(1)) u_lbc_top (
      .clk_sys(clk_sys), .rst_b(rst_b), .bankEnable(bankEnable),
      .bankLinear(bankLinear), .bankPulseEn(bankPulseEn),
      .bankZoneEn(bankZoneEn), .bankSetThree(bankSetThree),
      .bankCode(bankCode), .fullScaleCurrent(fullScaleCurrent),
      .startupTime(startupTime), .shutdownTime(shutdownTime),
      .rampUpTime(rampUpTime), .rampDownTime(rampDownTime),
      .pulseIn(pulseIn), .pulseActiveLow(pulseActiveLow),
      .sensorCfg(sensorCfg), .resistorSelect(resistorSelect),
      .zoneBoundHigh(zoneBoundHigh), .zoneBoundLow(zoneBoundLow),
      .zoneTargetSetOne(zoneTargetSetOne),
      .zoneTargetSetTwo(zoneTargetSetTwo),
      .zoneTargetSetThree(zoneTargetSetThree), .zonePulseEn(zonePulseEn),
      .converterCode(converterCode), .converterStart(converterStart),
      .sensorPulseMode(sensorPulseMode),
      .resistorEffective(resistorEffective),
      .lightSampleResult(lightSampleResult), .lightZone(lightZone),
      .pulseDuty(pulseDuty), .sinkCurrent(sinkCurrent));

   lbc_sensor_model u_lbc_sensor_model (.clk_sys(clk_sys), .rst_b(rst_b),
      .converterStart(converterStart), .lightLevel(lightLevel),
      .converterCode(converterCode));

   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected zone after one sample
   function automatic logic [2:0] next_zone(input logic [2:0] z,
      input logic [7:0] v);
      logic [7:0] hi;
      logic [7:0] lo;
      hi = 8'h37 + 8'h32 * z;
      lo = 8'h23 + 8'h32 * (z - 3'h1);
      if (z < 3'h4 && v > hi)
         return z + 3'h1;
      if (z > 3'h0 && v < lo)
         return z - 3'h1;
      return z;
   endfunction

   // expected linear current, optionally duty scaled
   function automatic logic [20:0] cur_lin(input logic [4:0] f,
      input logic [7:0] c, input logic scaled, input logic [7:0] d);
      logic [31:0] frac;
      frac = {24'h0, c} * 32'h101;
      if (scaled)
         frac = (frac * ({24'h0, d} * 32'h101)) >> 16;
      return 21'(frac * {27'h0, f});
   endfunction

   task automatic check(input string what, input logic [20:0] seen,
      input logic [20:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // wait for the next conversion start, counting edges
   task automatic wait_start(output int g);
      g = 0;
      do
      begin
         @(posedge clk_sys);
         #1;
         g++;
      end while (converterStart !== 1'b1 && g < 100);
      if (converterStart !== 1'b1)
      begin
         num_errors++;
         end_of_test();
      end
   endtask

   // wait for a bank current to settle, then see that it stays
   task automatic wait_current(input int b, input logic [20:0] exp);
      int n;
      n = 0;
      while (sinkCurrent[21*b +: 21] !== exp && n < 3000)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check("sinkCurrent", sinkCurrent[21*b +: 21], exp);
      repeat (250) @(posedge clk_sys);
      check("sinkCurrent held", sinkCurrent[21*b +: 21], exp);
   endtask

   initial
   begin
      {clk_sys, rst_b, pulseIn, pulseActiveLow} = 4'h0;
      {bankEnable, bankLinear, bankPulseEn, bankZoneEn, bankSetThree} = '0;
      {startupTime, shutdownTime, rampUpTime, rampDownTime} = 12'h000;
      {bankCode, fullScaleCurrent, sensorCfg, resistorSelect} = '0;
      zoneBoundHigh = 32'hCD9B6937;
      zoneBoundLow = 32'hB9875523;
      zoneTargetSetOne = 40'h0504030201;
      zoneTargetSetTwo = 40'h0000000005;
      zoneTargetSetThree = 40'h0000000002;
      {zonePulseEn, lightLevel, num_errors, n_checks} = '0;
      seed = 32'h2783;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1;
      check("lightZone", lightZone, 3'h0);
      check("lightSampleResult", lightSampleResult, 8'h00);
      check("sinkCurrent", sinkCurrent[20:0], 21'h0);
      // sensor type and load resistor
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         @(posedge clk_sys);
         sensorCfg <= {6'h00, seed[8], 1'b0};
         resistorSelect <= seed[6:0];
         @(posedge clk_sys);
         #1;
         check("resistorEffective", resistorEffective,
            seed[8] ? 7'h00 : seed[6:0]);
      end
      $display("end of sensor mode test");
      // duty measurement, both polarities
      @(posedge clk_sys);
      pulseIn <= 1'b1;
      pulseActiveLow <= 1'b1;
      repeat (600) @(posedge clk_sys);
      check("pulseDuty low", pulseDuty, 8'h00);
      pulseActiveLow <= 1'b0;
      repeat (600) @(posedge clk_sys);
      check("pulseDuty high", pulseDuty, 8'hFF);
      $display("end of duty test");
      // register mode ramp, duty scaling and shutdown on bank 1
      seed = lfsr(seed);
      fs = seed[4:0] | 5'h01;
      code = {5'h00, seed[7:5]} + 8'h01;
      bankLinear[0] <= 1'b1;
      bankCode[7:0] <= code;
      fullScaleCurrent[4:0] <= fs;
      bankEnable[0] <= 1'b1;
      wait_current(0, cur_lin(fs, code, 1'b0, 8'h00));
      bankPulseEn[0] <= 1'b1;
      wait_current(0, cur_lin(fs, code, 1'b1, 8'hFF));
      pulseActiveLow <= 1'b1;
      wait_current(0, 21'h0);
      {bankPulseEn[0], pulseActiveLow} <= 2'b00;
      wait_current(0, cur_lin(fs, code, 1'b0, 8'h00));
      bankEnable[0] <= 1'b0;
      wait_current(0, 21'h0);
      $display("end of current test");
      // zone walk with hysteresis, fixed levels then random ones
      sensorCfg <= 8'h01;
      zone = 3'h0;
      for (int i = 0; i < 16; i++)
      begin
         seed = lfsr(seed);
         // first start samples the held code, second the level it took
         zone = next_zone(zone, converterCode);
         wait_start(gap);
         zone = next_zone(zone, lightLevel);
         @(posedge clk_sys);
         lightLevel <= (i < 8) ? 8'(64'h5080B0F0FFC03000 >> (8 * (7 - i)))
            : seed[7:0];
         wait_start(gap);
         wait_start(gap);
         check("sample gap", 21'(gap), 21'd20);
         check("lightSampleResult", lightSampleResult, lightLevel);
         zone = next_zone(zone, lightLevel);
         @(posedge clk_sys);
         #1;
         check("lightZone", lightZone, zone);
      end
      @(posedge clk_sys);
      sensorCfg <= 8'h00;
      repeat (2) @(posedge clk_sys);
      check("lightZone off", lightZone, 3'h0);
      $display("end of zone test");
      // light zone target from set three on bank 2
      {bankZoneEn[1], bankSetThree[1], bankLinear[1]} <= 3'b111;
      fullScaleCurrent[9:5] <= fs;
      bankEnable[1] <= 1'b1;
      wait_current(1, cur_lin(fs, 8'h02, 1'b0, 8'h00));
      $display("end of target set test");
      end_of_test();
   end
endmodule
`default_nettype wire
